// ==== prs_regs.svh ====
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

// ----------------------------------------------------------------
// Clock rates
// ----------------------------------------------------------------
`define PRS_CLK_PERIOD_PS 5000
`define PRS_CORE_PERIOD_PS 12500

// ----------------------------------------------------------------
// Line and frame timing
// ----------------------------------------------------------------
`define PRS_LINE_TIME_NS 200
`define PRS_LINE_CYC ((`PRS_LINE_TIME_NS * 1000) / `PRS_CLK_PERIOD_PS)
`define PRS_MARGIN_NS 10
`define PRS_MARGIN_CYC \
    ((`PRS_MARGIN_NS * 1000 + `PRS_CLK_PERIOD_PS - 1) / `PRS_CLK_PERIOD_PS)
`define PRS_FRAME_LINES 928
`define PRS_CLAMP_PHASE 2

// ----------------------------------------------------------------
// Start-up sequence
// ----------------------------------------------------------------
`define PRS_LOAD_LINES 6
`define PRS_RO_LOAD_LINE 5

// ----------------------------------------------------------------
// Digital sync marker, in core-clock cycles then in clk cycles
// ----------------------------------------------------------------
`define PRS_MK_DELAY_CORE 2
`define PRS_MK_WIDTH_CORE 4
`define PRS_MK_DELAY_CYC ((`PRS_MK_DELAY_CORE * `PRS_CORE_PERIOD_PS \
    + `PRS_CLK_PERIOD_PS - 1) / `PRS_CLK_PERIOD_PS)
`define PRS_MK_WIDTH_CYC \
    ((`PRS_MK_WIDTH_CORE * `PRS_CORE_PERIOD_PS) / `PRS_CLK_PERIOD_PS)

// ----------------------------------------------------------------
// Array sizes
// ----------------------------------------------------------------
`define PRS_COLS 960
`define PRS_LATCHES 2752

`endif

// ==== prs_pkg.sv ====
package prs_pkg;

    typedef enum logic [2:0] {
        PRS_IDLE = 3'h0,
        PRS_SRST = 3'h1,
        PRS_WAIT_FALL = 3'h2,
        PRS_LOAD = 3'h3,
        PRS_RUN = 3'h4
    } prs_state_e;

    typedef logic [5:0] prs_phase_t;
    typedef logic [9:0] prs_row_t;

endpackage : prs_pkg

// ==== prs_line_timer.sv ====
`timescale 1ns/100ps
`include "prs_regs.svh"

module prs_line_timer
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset_n,
    input wire logic run,
    output prs_pkg::prs_phase_t phase,
    output logic line_end,
    output logic row_clk,
    output logic row_fall,
    output logic line_sync,
    output logic clamp,
    output logic stage_done
);
    import prs_pkg::*;

    prs_phase_t phase_reg;
    prs_phase_t phase_next;

    assign phase = phase_reg;

    always_comb
    begin
        phase_next = 6'h00;
        if (run && phase_reg != 6'(`PRS_LINE_CYC - 1))
        begin
            phase_next = phase_reg + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // Phase counter, one line per wrap
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge power_on_reset_n)
    begin
        if (!power_on_reset_n)
        begin
            phase_reg <= 6'h00;
        end
        else if (reset)
        begin
            phase_reg <= 6'h00;
        end
        else
        begin
            phase_reg <= phase_next; // see (R7)
        end
    end

    // ------------------------------------------------------------
    // Strobes, each one cycle behind the phase it decodes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge power_on_reset_n)
    begin
        if (!power_on_reset_n)
        begin
            line_end <= 1'b0;
            row_clk <= 1'b0;
            row_fall <= 1'b0;
            line_sync <= 1'b0;
            clamp <= 1'b0;
            stage_done <= 1'b0;
        end
        else if (reset)
        begin
            line_end <= 1'b0;
            row_clk <= 1'b0;
            row_fall <= 1'b0;
            line_sync <= 1'b0;
            clamp <= 1'b0;
            stage_done <= 1'b0;
        end
        else
        begin
            line_end <= run && phase_reg == 6'(`PRS_LINE_CYC - 1);
            row_clk <= run && phase_reg < 6'(`PRS_LINE_CYC / 2); // see (R12)
            row_fall <= run && phase_reg == 6'(`PRS_LINE_CYC / 2);
            // One common edge for every pipeline latch
            line_sync <= run && phase_reg == 6'h00; // see (R9)
            clamp <= run && phase_reg == 6'(`PRS_CLAMP_PHASE); // see (R12)
            // Stages must be settled this many cycles before the sync
            stage_done <= run &&
                phase_reg == 6'(`PRS_LINE_CYC - `PRS_MARGIN_CYC); // see (R8)
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_line_period: assert property ( // see (R7)
        @(posedge clk) disable iff (reset || !power_on_reset_n || !run)
        line_sync |-> ##40 line_sync)
        else $error("line sync not every 40 cycles");

    sequence prs_done_then_sync;
        !line_sync ##1 line_sync;
    endsequence

    chk_stage_margin: assert property ( // see (R8)
        @(posedge clk) disable iff (reset || !power_on_reset_n || !run)
        stage_done |-> ##1 prs_done_then_sync)
        else $error("stage done not 2 cycles before line sync");

endmodule : prs_line_timer

// ==== prs_main_sequencer.sv ====
`timescale 1ns/100ps
`include "prs_regs.svh"

// Operation
// (R1) Frames repeat back to back without any command while the clock runs.
// (R2) Start raised again abandons the frame and restarts from the first phase.
// (R3) Start high on two clock edges asserts both sequencer resets.
// (R4) After start falls, next row clock fall begins pattern load, hold high.
// (R5) Readout pattern is transferred during load line five.
// (R6) Hold falling starts the pixel machine and matrix readout.
// (R7) Every pipeline stage gets one line time of 200 ns.
// (R8) Stage work ends at least 10 ns before its line sync edge.
// (R9) All pipeline latches update together on the line sync edge.
// (R10) Pixel power-on rises with start and stays high.
// (R11) All 960 columns are sampled and discriminated in parallel.
// (R12) Row clock, alternate row clock at half rate, one clamp per line.
// (R13) A 960-bit mask suppresses chosen column discriminator outputs.
// (R14) Mask changes only through a new load and start, never while running.
// (R15) Power-on reset is asynchronous, active low, held over 1 us.
// (R16) A frame is 928 line times, next frame follows at once.
// (R17) Sync marker rises two core cycles after frame start, lasts four.
// (R18) During sequencer reset all state returns initial, config is latched.
// (R19) Row counter wraps from last row to zero with no idle line.
// (R20) Start level passes two synchronizer flip-flops before use.
module prs_main_sequencer
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset_n,
    input wire logic start,
    input wire logic [`PRS_COLS-1:0] disc_mask_cfg,
    input wire logic [`PRS_COLS-1:0] disc_raw,
    output logic seq_rst_a_n,
    output logic seq_rst_d_n,
    output logic pix_power_on,
    output logic load_hold,
    output logic pix_pattern_load,
    output logic ro_pattern_load,
    output logic pix_fsm_run,
    output logic row_clk,
    output logic row_alt_clk,
    output logic clamp,
    output logic line_sync,
    output logic stage_done,
    output logic frame_start,
    output logic sync_marker,
    output prs_pkg::prs_row_t row_index,
    output logic [`PRS_COLS-1:0] disc_out
);
    import prs_pkg::*;

    logic [2:0] start_sync_reg;
    logic start_hi;
    prs_state_e state_reg;
    prs_state_e state_next;
    logic run;
    logic line_end;
    logic row_fall;
    logic [2:0] load_cnt_reg;
    prs_row_t row_reg;
    logic [4:0] mk_cnt_reg;
    logic [`PRS_COLS-1:0] mask_reg;

    // ------------------------------------------------------------
    // Start synchronizer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge power_on_reset_n) // see (R15)
    begin
        if (!power_on_reset_n)
            start_sync_reg <= 3'h0;
        else if (reset)
            start_sync_reg <= 3'h0;
        else
            start_sync_reg <= {start_sync_reg[1:0], start}; // see (R20)
    end
    // Two consecutive synchronized samples high
    assign start_hi = start_sync_reg[1] && start_sync_reg[2]; // see (R3)

    // ------------------------------------------------------------
    // Start-up and run sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            PRS_IDLE: state_next = PRS_IDLE;
            PRS_SRST:
                if (!start_sync_reg[1])
                    state_next = PRS_WAIT_FALL;
            PRS_WAIT_FALL:
                if (row_fall)
                    state_next = PRS_LOAD; // see (R4)
            PRS_LOAD:
                if (line_end && load_cnt_reg == 3'(`PRS_LOAD_LINES - 1))
                    state_next = PRS_RUN; // see (R6)
            // No exit: frames run until a new start or reset
            PRS_RUN: state_next = PRS_RUN; // see (R1)
            default: state_next = PRS_IDLE;
        endcase
        // Start wins from any state, current frame is dropped
        if (start_hi)
            state_next = PRS_SRST; // see (R2)
    end

    always_ff @(posedge clk or negedge power_on_reset_n)
    begin
        if (!power_on_reset_n)
            state_reg <= PRS_IDLE;
        else if (reset)
            state_reg <= PRS_IDLE;
        else
            state_reg <= state_next;
    end

    assign run = state_reg != PRS_IDLE && state_reg != PRS_SRST;

    prs_line_timer u_line_timer
    (
        .clk(clk),
        .reset(reset),
        .power_on_reset_n(power_on_reset_n),
        .run(run),
        .phase(),
        .line_end(line_end),
        .row_clk(row_clk),
        .row_fall(row_fall),
        .line_sync(line_sync),
        .clamp(clamp),
        .stage_done(stage_done)
    );

    // ------------------------------------------------------------
    // Control outputs and counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge power_on_reset_n)
    begin
        if (!power_on_reset_n)
        begin
            seq_rst_a_n <= 1'b1;
            seq_rst_d_n <= 1'b1;
            pix_power_on <= 1'b0;
            load_hold <= 1'b0;
            pix_pattern_load <= 1'b0;
            ro_pattern_load <= 1'b0;
            pix_fsm_run <= 1'b0;
            load_cnt_reg <= 3'h0;
        end
        else if (reset)
        begin
            seq_rst_a_n <= 1'b1;
            seq_rst_d_n <= 1'b1;
            pix_power_on <= 1'b0;
            load_hold <= 1'b0;
            pix_pattern_load <= 1'b0;
            ro_pattern_load <= 1'b0;
            pix_fsm_run <= 1'b0;
            load_cnt_reg <= 3'h0;
        end
        else
        begin
            seq_rst_a_n <= state_reg != PRS_SRST; // see (R3)
            seq_rst_d_n <= state_reg != PRS_SRST; // see (R3)
            if (start_hi)
                pix_power_on <= 1'b1; // see (R10)
            load_hold <= state_reg == PRS_LOAD; // see (R4)
            pix_pattern_load <= state_reg == PRS_LOAD; // see (R4)
            ro_pattern_load <= state_reg == PRS_LOAD &&
                load_cnt_reg == 3'(`PRS_RO_LOAD_LINE); // see (R5)
            pix_fsm_run <= state_reg == PRS_RUN; // see (R6)
            if (state_reg != PRS_LOAD)
                load_cnt_reg <= 3'h0; // see (R18)
            else if (line_end)
                load_cnt_reg <= load_cnt_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Row counting, frame start and sync marker
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge power_on_reset_n)
    begin
        if (!power_on_reset_n)
        begin
            row_reg <= 10'h000;
            row_alt_clk <= 1'b0;
            frame_start <= 1'b0;
            mk_cnt_reg <= 5'h00;
            sync_marker <= 1'b0;
        end
        else if (reset || state_reg != PRS_RUN)
        begin
            row_reg <= 10'h000; // see (R18)
            row_alt_clk <= 1'b0;
            frame_start <= 1'b0;
            mk_cnt_reg <= 5'h00;
            sync_marker <= 1'b0;
        end
        else
        begin
            if (line_end)
            begin
                row_alt_clk <= !row_alt_clk; // see (R12)
                if (row_reg == 10'(`PRS_FRAME_LINES - 1))
                    row_reg <= 10'h000; // see (R19)
                else
                    row_reg <= row_reg + 10'h001; // see (R16)
            end
            frame_start <= line_sync && row_reg == 10'h000; // see (R16)
            if (frame_start)
                mk_cnt_reg <= 5'h01; // see (R17)
            else if (mk_cnt_reg ==
                5'(`PRS_MK_DELAY_CYC + `PRS_MK_WIDTH_CYC - 1))
                mk_cnt_reg <= 5'h00;
            else if (mk_cnt_reg != 5'h00)
                mk_cnt_reg <= mk_cnt_reg + 5'h01;
            sync_marker <= mk_cnt_reg >= 5'(`PRS_MK_DELAY_CYC - 1) &&
                mk_cnt_reg <= 5'(`PRS_MK_DELAY_CYC + `PRS_MK_WIDTH_CYC - 2);
        end
    end

    assign row_index = row_reg;

    // ------------------------------------------------------------
    // Discriminator mask and column outputs
    // ------------------------------------------------------------
    // Mask only loads in sequencer reset, so it cannot glitch mid-frame
    always_ff @(posedge clk or negedge power_on_reset_n)
    begin
        if (!power_on_reset_n)
            mask_reg <= '0;
        else if (reset)
            mask_reg <= '0;
        else if (state_reg == PRS_SRST)
            mask_reg <= disc_mask_cfg; // see (R14)
    end

    for (genvar col = 0; col < `PRS_COLS; col++)
    begin : g_col
        always_ff @(posedge clk or negedge power_on_reset_n)
        begin
            if (!power_on_reset_n)
                disc_out[col] <= 1'b0;
            else if (reset || state_reg != PRS_RUN)
                disc_out[col] <= 1'b0;
            else if (line_sync)
                disc_out[col] <= disc_raw[col] && // see (R11)
                    !mask_reg[col]; // see (R13)
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking prs_cb @(posedge clk);
    endclocking
    default disable iff (reset || !power_on_reset_n);
    chk_start_resets: assert property ( // see (R3)
        start_hi |-> ##2 (!seq_rst_a_n && !seq_rst_d_n))
        else $error("sequencer resets not asserted after start");

    chk_power_stays: assert property ( // see (R10)
        pix_power_on |=> pix_power_on)
        else $error("pixel power-on dropped");

    chk_load_after_fall: assert property ( // see (R4)
        (state_reg == PRS_WAIT_FALL && row_fall && !start_hi)
        |-> ##2 (load_hold && pix_pattern_load))
        else $error("pattern load did not follow row clock fall");

    chk_ro_in_load: assert property ( // see (R5)
        $rose(ro_pattern_load) |-> load_hold && $past(load_cnt_reg) == 3'h5)
        else $error("readout pattern loaded outside line five");

    chk_run_after_hold: assert property ( // see (R6)
        ($fell(load_hold) && seq_rst_a_n) |-> pix_fsm_run)
        else $error("pixel machine not started on hold fall");

    chk_mask_frozen: assert property ( // see (R14)
        (state_reg == PRS_RUN && $past(state_reg) == PRS_RUN)
        |-> $stable(mask_reg))
        else $error("mask changed during readout");

    chk_row_wrap: assert property ( // see (R19)
        (state_reg == PRS_RUN && !start_hi && line_end && row_reg == 10'h39F)
        |=> row_reg == 10'h000)
        else $error("row counter did not wrap to zero");

    sequence prs_marker_shape;
        !sync_marker[*4] ##1 sync_marker[*8] ##1 sync_marker[*2]
        ##1 !sync_marker;
    endsequence

    chk_sync_marker: assert property ( // see (R17)
        (frame_start && !start_hi) ##1 (state_reg == PRS_RUN)
        |-> prs_marker_shape)
        else $error("sync marker delay or width wrong");

endmodule : prs_main_sequencer

// ==== prs_ctrl_model.sv ====
`timescale 1ns/100ps
`include "prs_regs.svh"

// ----------------------------------------------------------------
// External readout controller: reset, mask load and start
// ----------------------------------------------------------------
module prs_ctrl_model
(
    input wire logic clk,
    output logic power_on_reset_n,
    output logic start,
    output logic [`PRS_COLS-1:0] disc_mask_cfg
);
    initial
    begin
        power_on_reset_n = 1'b0;
        start = 1'b0;
        disc_mask_cfg = '0;
    end

    // 220 cycles keeps a margin over the 1 us floor
    task automatic do_por();
        repeat (220) @(negedge clk);
        power_on_reset_n = 1'b1;
    endtask : do_por

    // Mask only counts once a new start follows it
    task automatic load_mask(input logic [`PRS_COLS-1:0] m);
        @(negedge clk);
        disc_mask_cfg = m;
    endtask : load_mask

    // Start may be raised at any time, even mid frame
    task automatic do_start(input int len);
        @(negedge clk);
        start = 1'b1;
        repeat (len) @(negedge clk);
        start = 1'b0;
    endtask : do_start
endmodule : prs_ctrl_model

// ==== test_prs_main_sequencer.sv ====
`timescale 1ns/100ps
`include "prs_regs.svh"

`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            fails++; \
            $display("Error at %0t: got %0h expected %0h", \
                $time, (a), (b)); \
        end \
    end

`define WAIT(c, n) \
    begin \
        k = 0; \
        while (!(c) && k < (n)) \
        begin \
            step(); \
            k++; \
        end \
    end

module test_prs_main_sequencer;
    import prs_pkg::*;

    localparam logic [`PRS_COLS-1:0] RAW = {240{4'hC}};
    localparam logic [`PRS_COLS-1:0] M0 = {240{4'hA}};
    localparam logic [`PRS_COLS-1:0] M1 = {240{4'h6}};

    logic clk;
    logic reset;
    logic power_on_reset_n;
    logic start;
    logic [`PRS_COLS-1:0] disc_mask_cfg;
    logic [`PRS_COLS-1:0] disc_raw;
    logic seq_rst_a_n;
    logic seq_rst_d_n;
    logic pix_power_on;
    logic load_hold;
    logic pix_pattern_load;
    logic ro_pattern_load;
    logic pix_fsm_run;
    logic row_clk;
    logic row_alt_clk;
    logic clamp;
    logic line_sync;
    logic stage_done;
    logic frame_start;
    logic sync_marker;
    prs_row_t row_index;
    logic [`PRS_COLS-1:0] disc_out;
    int fails = 0;
    int comparisons = 0;
    int k;

    prs_ctrl_model i_ctrl
    (
        .clk(clk),
        .power_on_reset_n(power_on_reset_n),
        .start(start),
        .disc_mask_cfg(disc_mask_cfg)
    );

    prs_main_sequencer i_dut
    (
        .clk(clk),
        .reset(reset),
        .power_on_reset_n(power_on_reset_n),
        .start(start),
        .disc_mask_cfg(disc_mask_cfg),
        .disc_raw(disc_raw),
        .seq_rst_a_n(seq_rst_a_n),
        .seq_rst_d_n(seq_rst_d_n),
        .pix_power_on(pix_power_on),
        .load_hold(load_hold),
        .pix_pattern_load(pix_pattern_load),
        .ro_pattern_load(ro_pattern_load),
        .pix_fsm_run(pix_fsm_run),
        .row_clk(row_clk),
        .row_alt_clk(row_alt_clk),
        .clamp(clamp),
        .line_sync(line_sync),
        .stage_done(stage_done),
        .frame_start(frame_start),
        .sync_marker(sync_marker),
        .row_index(row_index),
        .disc_out(disc_out)
    );

    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        disc_raw = '0;
    end

    always #2.5 clk = ~clk;

    // Sample just after the edge so its updates have landed
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic print_verdict();
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic t_idle();
        `CHK(seq_rst_a_n, 1'b1)
        `CHK(pix_power_on, 1'b0)
        `CHK(pix_fsm_run, 1'b0)
        `CHK(disc_out, '0)
    endtask : t_idle

    task automatic t_start();
        int ro;
        ro = 0;
        i_ctrl.do_start(6);
        `WAIT(seq_rst_a_n === 1'b0, 12)
        `CHK(seq_rst_a_n, 1'b0)
        `CHK(seq_rst_d_n, 1'b0)
        `CHK(pix_power_on, 1'b1)
        `WAIT(load_hold === 1'b1, 200)
        `CHK(load_hold, 1'b1)
        `CHK(pix_pattern_load, 1'b1)
        `CHK(row_clk, 1'b0)
        `WAIT(load_hold !== 1'b1 || ro_pattern_load === 1'b1, 400)
        while (ro_pattern_load === 1'b1 && ro < 400)
        begin
            ro++;
            step();
        end
        `CHK(ro, `PRS_LINE_CYC)
        `WAIT(load_hold !== 1'b1, 400)
        `CHK(pix_fsm_run, 1'b1)
        `CHK(pix_power_on, 1'b1)
    endtask : t_start

    task automatic t_frame();
        int i;
        int first;
        int cnt;
        prs_row_t mx;
        i = 0;
        first = 0;
        cnt = 0;
        mx = '0;
        `WAIT(frame_start === 1'b1, 200)
        `CHK(row_index, '0)
        do
        begin
            step();
            i++;
            if (sync_marker === 1'b1 && i < 40)
            begin
                cnt++;
                if (first == 0)
                    first = i;
            end
            if (row_index > mx)
                mx = row_index;
        end
        while (frame_start !== 1'b1 && i < 40000);
        `CHK(i, `PRS_LINE_CYC * `PRS_FRAME_LINES)
        `CHK(mx, prs_row_t'(`PRS_FRAME_LINES - 1))
        `CHK(first, `PRS_MK_DELAY_CYC)
        `CHK(cnt, `PRS_MK_WIDTH_CYC)
    endtask : t_frame

    task automatic t_line();
        int ls;
        int cl;
        int sd;
        int hi;
        logic alt0;
        ls = 0;
        cl = 0;
        sd = 0;
        hi = 0;
        step();
        `WAIT(line_sync === 1'b1, 50)
        alt0 = row_alt_clk;
        for (int i = 1; i <= `PRS_LINE_CYC; i++)
        begin
            step();
            if (clamp === 1'b1)
                cl++;
            if (stage_done === 1'b1)
                sd = i;
            if (row_clk === 1'b1)
                hi++;
            if (line_sync === 1'b1 && ls == 0)
                ls = i;
        end
        `CHK(ls, `PRS_LINE_CYC)
        `CHK(sd, `PRS_LINE_CYC - `PRS_MARGIN_CYC)
        `CHK(cl, 1)
        `CHK(hi, `PRS_LINE_CYC / 2)
        `CHK(row_alt_clk, ~alt0)
    endtask : t_line

    // Second line uses inverted raw data; a mask loaded mid run must not apply
    task automatic t_disc(input logic [`PRS_COLS-1:0] m);
        for (int n = 0; n < 2; n++)
        begin
            @(negedge clk);
            disc_raw = n == 0 ? RAW : ~RAW;
            step();
            `WAIT(line_sync === 1'b1, 50)
            step();
            `CHK(disc_out, disc_raw & ~m)
            i_ctrl.load_mask(~m);
        end
        i_ctrl.load_mask(m);
    endtask : t_disc

    task automatic t_restart();
        i_ctrl.load_mask(M1);
        i_ctrl.do_start(6);
        `CHK(pix_fsm_run, 1'b0)
        `CHK(row_index, '0)
        `CHK(seq_rst_d_n, 1'b0)
        `CHK(pix_power_on, 1'b1)
        `CHK(disc_out, '0)
        `WAIT(pix_fsm_run === 1'b1, 400)
        `CHK(pix_fsm_run, 1'b1)
        t_disc(M1);
    endtask : t_restart

    task automatic t_sreset();
        @(negedge clk);
        reset = 1'b1;
        step();
        @(negedge clk);
        reset = 1'b0;
        t_idle();
    endtask : t_sreset

    // Bound covers one frame plus start-up, with headroom
    initial
    begin
        #(60000 * 5);
        fails++;
        print_verdict();
    end

    initial
    begin
        i_ctrl.load_mask(M0);
        repeat (4) @(negedge clk);
        reset = 1'b0;
        i_ctrl.do_por();
        step();
        t_idle();
        t_start();
        t_frame();
        t_line();
        t_disc(M0);
        t_restart();
        t_sreset();
        print_verdict();
    end
endmodule : test_prs_main_sequencer
